//--- vic_core.sv
// Notes on behaviour
// - up to 64 request inputs, each with its own enable, class select and pending bit.
// - software sees 32-bit words, so each 64-source set is split into a high and low word.
// - two request outputs go to the core, one normal class and one fast class.
// - a per-source select bit routes an active source to the normal or to the fast output.
// - normal and fast pending sources are readable in separate register pairs.
// - a vector register gives the number of the highest-priority pending source.
// - a disabled source drives neither output and its enable touches no other source.
// - software can force a source, and the forced request acts like a real one.
// - normal sources carry one of 16 levels and a mask hides levels not above the mask.
// - one bit blocks all normal requests and another blocks all fast requests.
`include "vic_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module vic_core (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [`VIC_SRC_COUNT-1:0] src_req,
    input wire vic_pkg::vic_bus_type bus,
    output logic [`VIC_WORD_BITS-1:0] rdata,
    output logic nrm_req,
    output logic fst_req,
    output logic evt_irq
);
    import vic_pkg::*;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] half(input logic [63:0] v, input logic hi);
        half = hi ? v[63:32] : v[31:0];
    endfunction

    // returns {found, level, number}; ties go to the later index
    function automatic logic [10:0] pick_top(input logic [63:0] p,
                                             input logic [63:0][3:0] lv);
        logic found;
        logic [3:0] best;
        logic [5:0] num;
        found = 1'b0;
        best = 4'h0;
        num = 6'h00;
        for (int k = 0; k < `VIC_SRC_COUNT; k++) begin
            if (p[k] && (!found || lv[k] >= best)) begin
                found = 1'b1;
                best = lv[k];
                num = 6'(k);
            end
        end
        pick_top = {found, best, num};
    endfunction

    vic_state_type st;
    vic_state_type next_st;

    logic [63:0] act;
    logic [63:0] npend;
    logic [63:0] fpend;
    logic [10:0] ntop;
    logic [10:0] ftop;

    // ----------------------------------------
    // per-source qualification
    // ----------------------------------------
    // levels only, no edge capture: a pulse shorter than a cycle may be missed
    genvar i;
    generate
        for (i = 0; i < `VIC_SRC_COUNT; i++) begin : g_src
            // forced request ored in before the enable
            assign act[i] = (src_req[i] | st.force_req[i]) & st.enable[i];
            assign npend[i] = act[i] & ~st.fast_sel[i]
                & (~st.mask_en | (st.prio[i] > st.mask_lvl));
            assign fpend[i] = act[i] & st.fast_sel[i];
        end
    endgenerate

    assign ntop = pick_top(npend, st.prio);
    assign ftop = pick_top(fpend, '0);

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        logic hi;
        logic [1:0] evt_set;
        logic [1:0] evt_clr;
        logic [2:0] pw;
        next_st = st;
        hi = 1'b0;
        evt_set = 2'b00;
        evt_clr = 2'b00;
        pw = bus.addr[4:2];

        // read data stands only in the cycle after the strobe
        next_st.rdata = 32'h0;
        if (bus.rd) begin
            unique case (bus.addr)
                `VIC_A_CTRL: begin
                    next_st.rdata[`VIC_CTRL_NRM_DIS] = st.nrm_dis;
                    next_st.rdata[`VIC_CTRL_FST_DIS] = st.fst_dis;
                    next_st.rdata[`VIC_CTRL_MASK_EN] = st.mask_en;
                    next_st.rdata[`VIC_CTRL_MASK_LSB +: 4] = st.mask_lvl;
                end
                `VIC_A_EN_HI, `VIC_A_EN_LO:
                    next_st.rdata = half(st.enable, bus.addr == `VIC_A_EN_HI);
                `VIC_A_SEL_HI, `VIC_A_SEL_LO:
                    next_st.rdata = half(st.fast_sel, bus.addr == `VIC_A_SEL_HI);
                `VIC_A_FRC_HI, `VIC_A_FRC_LO:
                    next_st.rdata = half(st.force_req, bus.addr == `VIC_A_FRC_HI);
                `VIC_A_SRC_HI, `VIC_A_SRC_LO:
                    next_st.rdata = half(src_req, bus.addr == `VIC_A_SRC_HI);
                `VIC_A_NP_HI, `VIC_A_NP_LO:
                    next_st.rdata = half(npend, bus.addr == `VIC_A_NP_HI);
                `VIC_A_FP_HI, `VIC_A_FP_LO:
                    next_st.rdata = half(fpend, bus.addr == `VIC_A_FP_HI);
                `VIC_A_VEC: begin
                    next_st.rdata[`VIC_VEC_NUM_LSB +: 6] = ntop[5:0];
                    next_st.rdata[`VIC_VEC_LVL_LSB +: 4] = ntop[9:6];
                    next_st.rdata[`VIC_VEC_NVALID] = ntop[10];
                    next_st.rdata[`VIC_VEC_FNUM_LSB +: 6] = ftop[5:0];
                    next_st.rdata[`VIC_VEC_FVALID] = ftop[10];
                end
                `VIC_A_EVT_STAT: next_st.rdata[1:0] = st.evt_stat;
                `VIC_A_EVT_MASK: next_st.rdata[1:0] = st.evt_mask;
                default: begin
                    if (bus.addr[7:5] == 3'b010) begin
                        for (int j = 0; j < `VIC_SRC_PER_PRIO_WORD; j++) begin
                            next_st.rdata[4*j +: 4] = st.prio[{pw, 3'(j)}];
                        end
                    end
                end
            endcase
        end

        // writes; each source owns its own bit, so one enable leaves others alone
        if (bus.wr) begin
            hi = bus.addr == `VIC_A_EN_HI || bus.addr == `VIC_A_SEL_HI
                || bus.addr == `VIC_A_FRC_HI;
            unique case (bus.addr)
                `VIC_A_CTRL: begin
                    next_st.nrm_dis = bus.wdata[`VIC_CTRL_NRM_DIS];
                    next_st.fst_dis = bus.wdata[`VIC_CTRL_FST_DIS];
                    next_st.mask_en = bus.wdata[`VIC_CTRL_MASK_EN];
                    next_st.mask_lvl = bus.wdata[`VIC_CTRL_MASK_LSB +: 4];
                end
                `VIC_A_EN_HI, `VIC_A_EN_LO: begin
                    if (hi) next_st.enable[63:32] = bus.wdata;
                    else next_st.enable[31:0] = bus.wdata;
                end
                `VIC_A_SEL_HI, `VIC_A_SEL_LO: begin
                    if (hi) next_st.fast_sel[63:32] = bus.wdata;
                    else next_st.fast_sel[31:0] = bus.wdata;
                end
                `VIC_A_FRC_HI, `VIC_A_FRC_LO: begin
                    if (hi) next_st.force_req[63:32] = bus.wdata;
                    else next_st.force_req[31:0] = bus.wdata;
                end
                `VIC_A_EVT_STAT: evt_clr = bus.wdata[1:0];
                `VIC_A_EVT_MASK: next_st.evt_mask = bus.wdata[1:0];
                default: begin
                    if (bus.addr[7:5] == 3'b010) begin
                        for (int j = 0; j < `VIC_SRC_PER_PRIO_WORD; j++) begin
                            next_st.prio[{pw, 3'(j)}] = bus.wdata[4*j +: 4];
                        end
                    end
                end
            endcase
        end

        // global blocks act after the pending sets, so pending stays visible
        next_st.nrm_req = (|npend) & ~st.nrm_dis;
        next_st.fst_req = (|fpend) & ~st.fst_dis;

        // rising request lines are logged; a set in the clear cycle survives
        evt_set[`VIC_EVT_NRM] = next_st.nrm_req & ~st.nrm_req;
        evt_set[`VIC_EVT_FST] = next_st.fst_req & ~st.fst_req;
        next_st.evt_stat = (st.evt_stat & ~evt_clr) | evt_set;
        next_st.evt_irq = |(next_st.evt_stat & next_st.evt_mask);
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign rdata = st.rdata;
    assign nrm_req = st.nrm_req;
    assign fst_req = st.fst_req;
    assign evt_irq = st.evt_irq;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_normal_line_cause: assert property (
        nrm_req |-> $past(|npend) && !$past(st.nrm_dis))
        else $error("normal request without a pending normal source");

    a_fast_line_cause: assert property (
        fst_req |-> $past(|fpend) && !$past(st.fst_dis))
        else $error("fast request without a pending fast source");

    a_normal_global_off: assert property (
        st.nrm_dis |=> !nrm_req)
        else $error("normal request while normal class disabled");

    a_fast_global_off: assert property (
        st.fst_dis |=> !fst_req)
        else $error("fast request while fast class disabled");

    a_disabled_all_quiet: assert property (
        (st.enable == 64'h0) |=> !nrm_req && !fst_req)
        else $error("request raised with every source disabled");

    a_forced_fast_src: assert property (
        (st.force_req[0] && st.enable[0] && st.fast_sel[0] && !st.fst_dis) |=> fst_req)
        else $error("forced fast source did not raise fast request");

    a_vector_is_pending: assert property (
        ntop[10] |-> npend[ntop[5:0]] && st.prio[ntop[5:0]] == ntop[9:6])
        else $error("vector names a source that is not pending");

    a_mask_hides_low: assert property (
        (ntop[10] && st.mask_en) |-> ntop[9:6] > st.mask_lvl)
        else $error("masked level reported as top");

    a_pending_split: assert property (
        (npend & fpend) == 64'h0)
        else $error("source pending in both classes");

    a_read_one_cycle: assert property (
        (bus.rd && bus.addr == `VIC_A_EN_LO) |=> rdata == $past(st.enable[31:0]) ##1
            ($past(bus.rd) || rdata == 32'h0))
        else $error("read data wrong or held too long");

    a_event_set_wins: assert property (
        (next_st.nrm_req && !st.nrm_req) |=> st.evt_stat[`VIC_EVT_NRM])
        else $error("rising normal request not logged");

endmodule // vic_core

`default_nettype wire

//--- vic_consts.svh
`ifndef VIC_CONSTS_SVH
`define VIC_CONSTS_SVH

// ----------------------------------------
// sizes
// ----------------------------------------
`define VIC_SRC_COUNT 64
`define VIC_WORD_BITS 32
`define VIC_ADDR_BITS 8
`define VIC_LVL_BITS 4
`define VIC_SRC_PER_PRIO_WORD 8

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define VIC_A_CTRL 8'h00
`define VIC_A_EN_HI 8'h04
`define VIC_A_EN_LO 8'h08
`define VIC_A_SEL_HI 8'h0c
`define VIC_A_SEL_LO 8'h10
`define VIC_A_FRC_HI 8'h14
`define VIC_A_FRC_LO 8'h18
`define VIC_A_SRC_HI 8'h1c
`define VIC_A_SRC_LO 8'h20
`define VIC_A_NP_HI 8'h24
`define VIC_A_NP_LO 8'h28
`define VIC_A_FP_HI 8'h2c
`define VIC_A_FP_LO 8'h30
`define VIC_A_VEC 8'h34
`define VIC_A_EVT_STAT 8'h38
`define VIC_A_EVT_MASK 8'h3c
`define VIC_A_PRIO_BASE 8'h40

// ----------------------------------------
// field positions
// ----------------------------------------
`define VIC_CTRL_NRM_DIS 0
`define VIC_CTRL_FST_DIS 1
`define VIC_CTRL_MASK_EN 4
`define VIC_CTRL_MASK_LSB 8
`define VIC_VEC_NUM_LSB 0
`define VIC_VEC_LVL_LSB 8
`define VIC_VEC_NVALID 15
`define VIC_VEC_FNUM_LSB 16
`define VIC_VEC_FVALID 31
`define VIC_EVT_NRM 0
`define VIC_EVT_FST 1

// ----------------------------------------
// reset values
// ----------------------------------------
`define VIC_RST_CTRL 12'h000
`define VIC_RST_WORD 64'h0

`endif

//--- vic_pkg.sv
package vic_pkg;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } vic_bus_type;

    typedef struct packed {
        logic nrm_dis;
        logic fst_dis;
        logic mask_en;
        logic [3:0] mask_lvl;
        logic [63:0] enable;
        logic [63:0] fast_sel;
        logic [63:0] force_req;
        logic [63:0][3:0] prio;
        logic [1:0] evt_stat;
        logic [1:0] evt_mask;
        logic nrm_req;
        logic fst_req;
        logic evt_irq;
        logic [31:0] rdata;
    } vic_state_type;

endpackage

//--- vic_core_model.sv
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// core side of the two request lines
// ----------------------------------------
module vic_core_model (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic nrm_req,
    input wire logic fst_req,
    output logic nrm_seen,
    output logic fst_seen
);
    // sticky, so a short level is not lost between polls
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            nrm_seen <= 1'b0;
            fst_seen <= 1'b0;
        end else begin
            nrm_seen <= nrm_seen | nrm_req;
            fst_seen <= fst_seen | fst_req;
        end
    end
endmodule // vic_core_model

`default_nettype wire

//--- vic_core_test.sv
`include "vic_consts.svh"
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_count++; $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end

// ----------------------------------------
// bench top
// ----------------------------------------
module vic_core_test;
    import vic_pkg::*;
    typedef struct packed {
        logic [7:0] src, en, sel, frc;
        logic [11:0] ctrl;
        logic n, f;
        logic [7:0] np;
    } vic_row_type;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [63:0] src_req = 64'h0;
    vic_bus_type bus = '0;
    logic [31:0] rdata;
    logic nrm_req, fst_req, evt_irq, nrm_seen, fst_seen;
    logic [31:0] d;
    int err_count = 0;
    int checks_done = 0;
    vic_row_type rows [8] = '{
        '{8'h00, 8'h01, 8'h01, 8'h01, 12'h000, 1'b0, 1'b1, 8'h00},
        '{8'h01, 8'h01, 8'h00, 8'h00, 12'h000, 1'b1, 1'b0, 8'h01},
        '{8'h01, 8'h01, 8'h01, 8'h00, 12'h000, 1'b0, 1'b1, 8'h00},
        '{8'h01, 8'h00, 8'h00, 8'h00, 12'h000, 1'b0, 1'b0, 8'h00},
        '{8'h00, 8'h01, 8'h00, 8'h01, 12'h000, 1'b1, 1'b0, 8'h01},
        '{8'h01, 8'h01, 8'h00, 8'h00, 12'h001, 1'b0, 1'b0, 8'h01},
        '{8'h01, 8'h01, 8'h01, 8'h00, 12'h002, 1'b0, 1'b0, 8'h00},
        '{8'h01, 8'h01, 8'h00, 8'h00, 12'h010, 1'b0, 1'b0, 8'h00}};

    vic_core vic_core_inst (.clk(clk), .sys_rst(sys_rst), .src_req(src_req), .bus(bus),
        .rdata(rdata), .nrm_req(nrm_req), .fst_req(fst_req), .evt_irq(evt_irq));
    vic_core_model vic_core_model_inst (.clk(clk), .sys_rst(sys_rst), .nrm_req(nrm_req),
        .fst_req(fst_req), .nrm_seen(nrm_seen), .fst_seen(fst_seen));

    initial begin
        forever #5 clk = ~clk;
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        bus <= '{a, v, 1'b1, 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask

    // read data only stand in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        bus <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 v = rdata;
    endtask

    task automatic st;
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        test_done;
    end

    initial begin
        repeat (20) @(posedge clk);
        #1 `CHK({nrm_req, fst_req, evt_irq}, 3'h0)
        sys_rst = 1'b0;
        rd(`VIC_A_EN_LO, d); `CHK(d, 32'h0)
        rd(`VIC_A_CTRL, d); `CHK(d, 32'h0)
        $display("test reset done");
        foreach (rows[i]) begin
            wr(`VIC_A_CTRL, {20'h0, rows[i].ctrl});
            wr(`VIC_A_EN_LO, {24'h0, rows[i].en});
            wr(`VIC_A_SEL_LO, {24'h0, rows[i].sel});
            wr(`VIC_A_FRC_LO, {24'h0, rows[i].frc});
            src_req <= {56'h0, rows[i].src};
            st;
            `CHK({nrm_req, fst_req}, {rows[i].n, rows[i].f})
            rd(`VIC_A_NP_LO, d); `CHK(d, {24'h0, rows[i].np})
        end
        $display("test rows done");
        // top source of the high word, low word left idle
        wr(`VIC_A_CTRL, 32'h0);
        wr(`VIC_A_EN_LO, 32'h0);
        wr(`VIC_A_FRC_LO, 32'h0);
        wr(`VIC_A_EN_HI, 32'h80000000);
        src_req <= 64'h8000000000000000;
        st;
        `CHK(nrm_req, 1'b1)
        rd(`VIC_A_NP_HI, d); `CHK(d, 32'h80000000)
        rd(`VIC_A_NP_LO, d); `CHK(d, 32'h0)
        $display("test high word done");
        // sources 3 and 5 at equal level, then source 3 raised
        wr(`VIC_A_EN_HI, 32'h0);
        wr(`VIC_A_EN_LO, 32'h28);
        wr(`VIC_A_PRIO_BASE, 32'h00505000);
        src_req <= 64'h28;
        st;
        rd(`VIC_A_VEC, d); `CHK(d, 32'h00008505)
        wr(`VIC_A_PRIO_BASE, 32'h00507000);
        st;
        rd(`VIC_A_VEC, d); `CHK(d, 32'h00008703)
        wr(`VIC_A_CTRL, 32'h510);
        st;
        rd(`VIC_A_VEC, d); `CHK(d, 32'h00008703)
        wr(`VIC_A_CTRL, 32'h710);
        st;
        `CHK(nrm_req, 1'b0)
        wr(`VIC_A_CTRL, 32'h0);
        wr(`VIC_A_SEL_LO, 32'h28);
        st;
        rd(`VIC_A_VEC, d); `CHK(d, 32'h80050000)
        $display("test vector done");
        // event status and its interrupt
        src_req <= 64'h0;
        wr(`VIC_A_EVT_MASK, 32'h2);
        wr(`VIC_A_EVT_STAT, 32'h3);
        st;
        `CHK(evt_irq, 1'b0)
        src_req <= 64'h8;
        st;
        `CHK({fst_req, evt_irq}, 2'h3)
        rd(`VIC_A_EVT_STAT, d); `CHK(d, 32'h2)
        src_req <= 64'h0;
        wr(`VIC_A_EVT_STAT, 32'h2);
        st;
        `CHK(evt_irq, 1'b0)
        rd(8'hfc, d); `CHK(d, 32'h0)
        `CHK({nrm_seen, fst_seen}, 2'h3)
        $display("test events done");
        // reset in mid-run with sources still enabled and pending
        src_req <= 64'h28;
        st;
        sys_rst = 1'b1;
        st;
        `CHK({nrm_req, fst_req, evt_irq, rdata}, 35'h0)
        `CHK({nrm_seen, fst_seen}, 2'h0)
        sys_rst = 1'b0;
        rd(`VIC_A_EN_LO, d); `CHK(d, 32'h0)
        st;
        `CHK({nrm_req, fst_req}, 2'h0)
        $display("test mid reset done");
        test_done;
    end
endmodule // vic_core_test

`default_nettype wire
